// ### core/adcs_sequencer.v
/*
 Sequencer control of a 10-bit converter with 16+8 multiplexed inputs:
 modes, scan, injection, wait-for-read, overrun, calibration, interrupts.
 Assumes a synchronous register port master and a converter core that
 returns a result with a valid level still high when the conversion time ends.
*/
// Functional notes
// (R01) 10-bit results, 16+8 channel select
// (R02) One bit selects the channel group
// (R03) Self-calibration runs after each reset
// (R04) Programmable sample and conversion times
// (R05) Overrun: interrupt or hold until read
// (R06) Unused analog inputs readable as digital
// (R07) Single mode converts once, stores result
// (R08) Continuous mode converts repeatedly
// (R09) Scan converts each selected channel once
// (R10) Continuous scan cycles channels forever
// (R11) Wait-for-read buffers result, pauses conversions
// (R12) Injected conversion accepted during repeating modes
// (R13) Injected result goes to secondary register
// (R14) Repeating mode resumes after injection
// (R15) Calibration within 40630 cycles, busy set
// (R16) No conversion start while calibrating
// (R17) Calibration never repeated in operation
// (R18) Result read clears pending, releases hold
// (R19) Completion event on each primary store
`timescale 1ns/1ps
`include "adcs_map.vh"
module adcs_sequencer #(
    parameter CAL_CYCLES = `ADCS_CAL_CYCLES,
    parameter RES_W      = 10,
    parameter NCH_A      = 16,
    parameter NCH_B      = 8
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [7:0]       regAddr,
    input  wire [31:0]      regWdata,
    input  wire             regWr,
    input  wire             regRd,
    output reg  [31:0]      regRdata,
    output reg              irq,
    output reg              sampleEn,
    output reg              convStart,
    output reg              calRun,
    output reg              muxGroup,
    output reg  [3:0]       muxChannel,
    input  wire             convValid,
    input  wire [RES_W-1:0] convResult,
    input  wire             calDone,
    input  wire [NCH_A-1:0] pinsGroupA,
    input  wire [NCH_B-1:0] pinsGroupB
);
    localparam CAL_W = 16;
    localparam [CAL_W-1:0] CAL_MAX = CAL_CYCLES;

    localparam [4:0] ST_CAL  = 5'b00001;
    localparam [4:0] ST_IDLE = 5'b00010;
    localparam [4:0] ST_SMP  = 5'b00100;
    localparam [4:0] ST_CNV  = 5'b01000;
    localparam [4:0] ST_HOLD = 5'b10000;

    ////////////////////////////////////////////////////////////////////
    // Registers
    reg [4:0]        state_reg;
    reg [CAL_W-1:0]  calCnt_reg;
    reg [3:0]        chan_reg;
    reg [1:0]        mode_reg;
    reg              waitRd_reg;
    reg              group_reg;
    reg              run_reg;
    reg              injReq_reg;
    reg [3:0]        injChan_reg;
    reg              injGroup_reg;
    reg              injAct_reg;
    reg [3:0]        curChan_reg;
    reg [RES_W-1:0]  prim_reg;
    reg [3:0]        primChan_reg;
    reg [RES_W-1:0]  inj_reg;
    reg [RES_W-1:0]  tmp_reg;
    reg [3:0]        tmpChan_reg;
    reg              pend_reg;
    reg [2:0]        irqSt_reg;
    reg [2:0]        irqMsk_reg;
    reg [15:0]       scanMsk_reg;
    reg [15:0]       time_reg;

    wire [15:0] smpLoad;
    wire [15:0] cnvLoad;
    wire        smpDone;
    wire        cnvDone;
    reg         smpStart;
    reg         cnvStart;

    wire isCont    = (mode_reg == `ADCS_M_CONT) ||
                     (mode_reg == `ADCS_M_SCANCONT);
    wire isScan    = mode_reg[1];
    wire wrCtrl    = regWr && (regAddr == `ADCS_CTRL_OFS);
    wire rdPrim    = regRd && (regAddr == `ADCS_PRIM_OFS);
    wire rdIrq     = regRd && (regAddr == `ADCS_IRQST_OFS);
    wire [3:0] maxChan = group_reg ? 4'h7 : 4'hF;

    ////////////////////////////////////////////////////////////////////
    // Next selected scan channel after the current one
    reg [3:0] nextScan;
    reg       scanWrap;
    reg       found;
    integer   i;
    always @* begin
        nextScan = 4'h0;
        scanWrap = 1'b1;
        found    = 1'b0;
        for (i = 0; i < 16; i = i + 1) begin
            if (!found && (i > curChan_reg) && (i <= maxChan) &&
                scanMsk_reg[i]) begin
                nextScan = i[3:0];
                scanWrap = 1'b0;
                found    = 1'b1;
            end
        end
        for (i = 0; i < 16; i = i + 1) begin
            if (!found && (i <= maxChan) && scanMsk_reg[i]) begin
                nextScan = i[3:0];
                found    = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Phase timers
    assign smpLoad = {8'h00, time_reg[`ADCS_T_SMP_MSB:`ADCS_T_SMP_LSB]};
    assign cnvLoad = {8'h00, time_reg[`ADCS_T_CNV_MSB:`ADCS_T_CNV_LSB]};

    adcs_timer #(.WIDTH(16)) smpTimer (
        .clk   (clk),
        .rst   (rst),
        .load  (smpStart),
        .value (smpLoad),
        .done  (smpDone)
    );

    adcs_timer #(.WIDTH(16)) cnvTimer (
        .clk   (clk),
        .rst   (rst),
        .load  (cnvStart),
        .value (cnvLoad),
        .done  (cnvDone)
    );

    ////////////////////////////////////////////////////////////////////
    // Sequencer
    wire startOk   = wrCtrl && regWdata[`ADCS_C_START];
    wire injOk     = injReq_reg && run_reg && isCont;                 // R12
    wire resultIn  = convValid && (state_reg == ST_CNV) && cnvDone;
    wire primStore = resultIn && !injAct_reg &&
                     !(pend_reg && waitRd_reg && isCont);
    wire toTmp     = resultIn && !injAct_reg && pend_reg &&
                     waitRd_reg && isCont;                            // R11
    wire holdRel   = (state_reg == ST_HOLD) && rdPrim;                // R18
    wire lastPass  = !isCont && (!isScan || scanWrap);

    always @* begin
        smpStart = 1'b0;
        cnvStart = 1'b0;
        if (state_reg == ST_IDLE && (run_reg || injOk))
            smpStart = 1'b1;                                          // R04
        if (state_reg == ST_SMP && smpDone)
            cnvStart = 1'b1;                                          // R04
        if (state_reg == ST_CNV && resultIn && !toTmp &&
            (!lastPass || injAct_reg))
            smpStart = 1'b1;
        if (holdRel)
            smpStart = 1'b1;
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg    <= ST_CAL;                                   // R03
            calCnt_reg   <= {CAL_W{1'b0}};
            curChan_reg  <= 4'h0;
            injAct_reg   <= 1'b0;
            run_reg      <= 1'b0;
            prim_reg     <= {RES_W{1'b0}};
            primChan_reg <= 4'h0;
            inj_reg      <= {RES_W{1'b0}};
            tmp_reg      <= {RES_W{1'b0}};
            tmpChan_reg  <= 4'h0;
            pend_reg     <= 1'b0;
        end else begin
            if (rdPrim)
                pend_reg <= 1'b0;                                     // R18
            case (state_reg)
                ST_CAL: begin
                    calCnt_reg <= calCnt_reg + {{(CAL_W-1){1'b0}}, 1'b1};
                    if (calDone || calCnt_reg >= CAL_MAX - 1)         // R15
                        state_reg <= ST_IDLE;                         // R17
                end
                ST_IDLE: begin
                    if (startOk) begin
                        run_reg     <= 1'b1;
                        curChan_reg <= regWdata[`ADCS_C_CH_MSB:
                                                `ADCS_C_CH_LSB];
                    end else if (smpStart) begin
                        injAct_reg <= injOk && !run_reg;
                        state_reg  <= ST_SMP;
                    end
                end
                ST_SMP: begin
                    if (smpDone)
                        state_reg <= ST_CNV;
                end
                ST_CNV: begin
                    if (resultIn) begin
                        if (injAct_reg) begin
                            inj_reg    <= convResult;                 // R13
                            injAct_reg <= 1'b0;                       // R14
                            state_reg  <= ST_SMP;
                        end else begin
                            if (primStore) begin
                                prim_reg     <= convResult;           // R07
                                primChan_reg <= curChan_reg;
                                pend_reg     <= 1'b1;
                            end else begin
                                tmp_reg     <= convResult;            // R11
                                tmpChan_reg <= curChan_reg;
                            end
                            if (isScan)
                                curChan_reg <= nextScan;              // R09
                            if (toTmp)
                                state_reg <= ST_HOLD;                 // R05
                            else if (lastPass) begin
                                run_reg   <= 1'b0;
                                state_reg <= ST_IDLE;
                            end else if (injOk) begin
                                injAct_reg <= 1'b1;                   // R12
                                state_reg  <= ST_SMP;
                            end else
                                state_reg <= ST_SMP;                  // R08
                        end
                    end
                end
                ST_HOLD: begin
                    if (rdPrim) begin
                        prim_reg     <= tmp_reg;                      // R11
                        primChan_reg <= tmpChan_reg;
                        pend_reg     <= 1'b1;
                        state_reg    <= ST_SMP;                       // R10
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
            if (wrCtrl && !regWdata[`ADCS_C_START] &&
                state_reg != ST_CAL && !isCont)
                run_reg <= run_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Software registers
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            chan_reg     <= 4'h0;
            mode_reg     <= `ADCS_M_SINGLE;
            waitRd_reg   <= 1'b0;
            group_reg    <= 1'b0;
            injReq_reg   <= 1'b0;
            injChan_reg  <= 4'h0;
            injGroup_reg <= 1'b0;
            irqMsk_reg   <= 3'h0;
            scanMsk_reg  <= 16'h0000;
            time_reg     <= `ADCS_TIME_RST;
        end else begin
            if (wrCtrl && state_reg != ST_CAL) begin                  // R16
                chan_reg     <= regWdata[`ADCS_C_CH_MSB:`ADCS_C_CH_LSB];
                mode_reg     <= regWdata[`ADCS_C_MODE_MSB:
                                         `ADCS_C_MODE_LSB];
                waitRd_reg   <= regWdata[`ADCS_C_WAIT];
                group_reg    <= regWdata[`ADCS_C_GRP];                // R02
                injChan_reg  <= regWdata[`ADCS_C_ICH_MSB:
                                         `ADCS_C_ICH_LSB];
                injGroup_reg <= regWdata[`ADCS_C_IGRP];
                if (regWdata[`ADCS_C_INJREQ])
                    injReq_reg <= 1'b1;
            end else if (injAct_reg && state_reg == ST_SMP)
                injReq_reg <= 1'b0;
            if (regWr && regAddr == `ADCS_IRQMSK_OFS)
                irqMsk_reg <= regWdata[2:0];
            if (regWr && regAddr == `ADCS_SCANMSK_OFS)
                scanMsk_reg <= regWdata[15:0];
            if (regWr && regAddr == `ADCS_TIME_OFS)
                time_reg <= regWdata[15:0];                           // R04
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt status: set wins over read-clear
    wire evDone = primStore || holdRel;                               // R19
    wire evOvr  = primStore && pend_reg && !rdPrim;                   // R05
    wire evInj  = resultIn && injAct_reg;
    wire [2:0] evVec = {evInj, evOvr, evDone};

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            irqSt_reg <= 3'h0;
            irq       <= 1'b0;
        end else begin
            irqSt_reg <= (rdIrq ? 3'h0 : irqSt_reg) | evVec;
            irq       <= |(((rdIrq ? 3'h0 : irqSt_reg) | evVec) &
                           irqMsk_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Converter-side outputs
    wire inCal = (state_reg == ST_CAL);
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sampleEn   <= 1'b0;
            convStart  <= 1'b0;
            calRun     <= 1'b1;
            muxGroup   <= 1'b0;
            muxChannel <= 4'h0;
        end else begin
            sampleEn   <= (state_reg == ST_SMP) && !smpDone;
            convStart  <= cnvStart;
            calRun     <= inCal;                                      // R15
            muxGroup   <= injAct_reg ? injGroup_reg : group_reg;      // R01
            muxChannel <= injAct_reg ? injChan_reg : curChan_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdata <= 32'h0000_0000;
        end else if (regRd) begin
            case (regAddr)
                `ADCS_CTRL_OFS:
                    regRdata <= {17'h0_0000, injGroup_reg, injChan_reg,
                                 injReq_reg, group_reg, waitRd_reg,
                                 run_reg, mode_reg, chan_reg};
                `ADCS_PRIM_OFS:
                    regRdata <= {16'h0000, primChan_reg,
                                 {(12-RES_W){1'b0}}, prim_reg};
                `ADCS_INJ_OFS:
                    regRdata <= {16'h0000, injChan_reg,
                                 {(12-RES_W){1'b0}}, inj_reg};        // R13
                `ADCS_STAT_OFS:
                    regRdata <= {27'h000_0000, injAct_reg,
                                 state_reg == ST_HOLD, pend_reg,
                                 run_reg, inCal};                     // R16
                `ADCS_IRQST_OFS:
                    regRdata <= {29'h0000_0000, irqSt_reg};
                `ADCS_IRQMSK_OFS:
                    regRdata <= {29'h0000_0000, irqMsk_reg};
                `ADCS_SCANMSK_OFS:
                    regRdata <= {16'h0000, scanMsk_reg};
                `ADCS_TIME_OFS:
                    regRdata <= {16'h0000, time_reg};
                `ADCS_PORT_OFS:
                    regRdata <= {8'h00, pinsGroupB, pinsGroupA};      // R06
                default:
                    regRdata <= 32'h0000_0000;
            endcase
        end else begin
            regRdata <= 32'h0000_0000;
        end
    end
endmodule

// ### core/adcs_map.vh
/*
 Register offsets, field positions, reset values and timing counts
 for the converter sequencer control block.
 Assumes inclusion by bare name from the core/ and dv/ files.
*/
`ifndef ADCS_MAP_VH
`define ADCS_MAP_VH

// Register byte offsets (register port address)
`define ADCS_CTRL_OFS      8'h00
`define ADCS_PRIM_OFS      8'h04
`define ADCS_INJ_OFS       8'h08
`define ADCS_STAT_OFS      8'h0C
`define ADCS_IRQST_OFS     8'h10
`define ADCS_IRQMSK_OFS    8'h14
`define ADCS_SCANMSK_OFS   8'h18
`define ADCS_TIME_OFS      8'h1C
`define ADCS_PORT_OFS      8'h20

// Control register fields
`define ADCS_C_CH_LSB      0
`define ADCS_C_CH_MSB      3
`define ADCS_C_MODE_LSB    4
`define ADCS_C_MODE_MSB    5
`define ADCS_C_START       6
`define ADCS_C_WAIT        7
`define ADCS_C_GRP         8
`define ADCS_C_INJREQ      9
`define ADCS_C_ICH_LSB     10
`define ADCS_C_ICH_MSB     13
`define ADCS_C_IGRP        14

// Conversion modes
`define ADCS_M_SINGLE      2'h0
`define ADCS_M_CONT        2'h1
`define ADCS_M_SCAN        2'h2
`define ADCS_M_SCANCONT    2'h3

// Status register fields
`define ADCS_S_BUSY        0
`define ADCS_S_CONV        1
`define ADCS_S_PEND        2
`define ADCS_S_HOLD        3
`define ADCS_S_INJ         4

// Interrupt status bits
`define ADCS_I_DONE        0
`define ADCS_I_OVR         1
`define ADCS_I_INJ         2

// Timing register fields, reset value
`define ADCS_T_SMP_LSB     0
`define ADCS_T_SMP_MSB     7
`define ADCS_T_CNV_LSB     8
`define ADCS_T_CNV_MSB     15
`define ADCS_TIME_RST      16'h1010

// Calibration lasts up to 40630 CPU clock cycles
`define ADCS_CAL_CYCLES    40630

`endif

// ### core/adcs_timer.v
/*
 Down counter used for the sample and conversion phases.
 Assumes load and run come from one clock domain, rst async high.
*/
`timescale 1ns/1ps
module adcs_timer #(
    parameter WIDTH = 16
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             load,
    input  wire [WIDTH-1:0] value,
    output reg              done
);
    reg [WIDTH-1:0] count_reg;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= {WIDTH{1'b0}};
            done      <= 1'b0;
        end else if (load) begin
            count_reg <= value;
            done      <= 1'b0;
        end else if (count_reg != {WIDTH{1'b0}}) begin
            count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
            done      <= (count_reg == {{(WIDTH-1){1'b0}}, 1'b1});
        end else begin
            done      <= 1'b0;
        end
    end
endmodule

// ### dv/adcs_sequencer_assertions.sv
/*
 Checker for the converter sequencer: register port, calibration, phases.
 Assumes binding to adcs_sequencer, one clock, rst async active high.
*/
`timescale 1ns/1ps
`include "adcs_map.vh"
module adcs_sequencer_checker #(
    parameter CAL_CYCLES = `ADCS_CAL_CYCLES
) (
    input wire        clk,
    input wire        rst,
    input wire [7:0]  regAddr,
    input wire [31:0] regWdata,
    input wire        regWr,
    input wire        regRd,
    input wire [31:0] regRdata,
    input wire        sampleEn,
    input wire        convStart,
    input wire        calRun,
    input wire        muxGroup,
    input wire [3:0]  muxChannel,
    input wire [15:0] pinsGroupA,
    input wire [7:0]  pinsGroupB
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    reg [15:0] calCnt_reg;
    reg [7:0]  smpTime_reg;
    reg [7:0]  smpCnt_reg;
    // Shadow of the sample time field and phase length counters
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            calCnt_reg <= 16'h0000;
            smpTime_reg <= 8'h10;
            smpCnt_reg <= 8'h00;
        end else begin
            if (calRun)
                calCnt_reg <= calCnt_reg + 16'h0001;
            if (regWr && regAddr == `ADCS_TIME_OFS)
                smpTime_reg <= regWdata[7:0];
            smpCnt_reg <= sampleEn ? smpCnt_reg + 8'h01 : 8'h00;
        end
    end
    sequence sSmpEnd;
        sampleEn ##1 !sampleEn;
    endsequence
    sequence sSampling;
        sampleEn ##1 sampleEn;
    endsequence
    AST_RD_IDLE: assert property (!regRd |=> regRdata == 32'h0000_0000)
        else $error("read data not zero outside answer cycle");
    AST_CAL_NO_CONV: assert property (
        calRun |-> !sampleEn && !convStart)
        else $error("conversion activity during calibration");
    AST_CAL_ONCE: assert property (!calRun |=> !calRun)
        else $error("calibration restarted without reset");
    AST_CAL_BOUND: assert property (
        calCnt_reg <= CAL_CYCLES + 1)
        else $error("calibration too long");
    AST_START_PULSE: assert property (
        convStart |=> !convStart && !sampleEn)
        else $error("conversion start not a single pulse");
    AST_SMP_THEN_CONV: assert property (
        sSmpEnd |-> ##[0:1] convStart)
        else $error("sample phase not followed by conversion");
    AST_SMP_LEN: assert property (
        $fell(sampleEn) |-> smpCnt_reg == smpTime_reg)
        else $error("sample phase length wrong");
    AST_MUX_HOLD: assert property (
        sSampling |-> $stable(muxChannel) && $stable(muxGroup))
        else $error("mux select moved while sampling");
    AST_PORT_READ: assert property (
        regRd && regAddr == `ADCS_PORT_OFS |=>
        regRdata[23:0] == $past({pinsGroupB, pinsGroupA}))
        else $error("pin levels read wrong");
endmodule
bind adcs_sequencer adcs_sequencer_checker #(.CAL_CYCLES(CAL_CYCLES)) u_chk (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .sampleEn(sampleEn), .convStart(convStart), .calRun(calRun),
    .muxGroup(muxGroup), .muxChannel(muxChannel),
    .pinsGroupA(pinsGroupA), .pinsGroupB(pinsGroupB));

// ### dv/adcs_core_model.sv
/*
 Model of the analog mux, sample-and-hold and converter core.
 Assumes the sequencer pulses convStart and holds calRun while calibrating.
*/
`timescale 1ns/1ps
module adcs_core_model #(
    parameter HOLD      = 8,
    parameter CAL_DELAY = 20
) (
    input  wire       clk,
    input  wire       rst,
    input  wire       calRun,
    input  wire       calHold,
    input  wire       convStart,
    input  wire       muxGroup,
    input  wire [3:0] muxChannel,
    output reg        convValid,
    output reg  [9:0] convResult,
    output reg        calDone
);
    reg [7:0]  hold_reg;
    reg [15:0] cal_reg;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            convValid <= 1'b0;
            convResult <= 10'h000;
            calDone <= 1'b0;
            hold_reg <= 8'h00;
            cal_reg <= 16'h0000;
        end else begin
            // Early end of calibration unless told to stall
            calDone <= calRun && !calHold && cal_reg >= CAL_DELAY;
            cal_reg <= calRun ? cal_reg + 16'h0001 : 16'h0000;
            if (convStart) begin
                convValid <= 1'b1;
                convResult <= {muxGroup, muxChannel, 5'h0D};
                hold_reg <= HOLD[7:0];
            end else if (hold_reg > 8'h01) begin
                hold_reg <= hold_reg - 8'h01;
            end else if (hold_reg == 8'h01) begin
                // Released data line shows the inverse of the last value
                hold_reg <= 8'h00;
                convValid <= 1'b0;
                convResult <= ~convResult;
            end
        end
    end
endmodule

// ### dv/tb.sv
/*
 Testbench of the converter sequencer driven over its register port.
 Assumes the core model on the far side and a 20 MHz clock.
*/
`timescale 1ns/1ps
`include "adcs_map.vh"
module tb;
    localparam CAL_CYC = 50;
    logic        clk, rst, regWr, regRd, irq, sampleEn, convStart, calRun;
    logic        muxGroup, convValid, calDone, calHold;
    logic [7:0]  regAddr, pinsGroupB;
    logic [31:0] regWdata, regRdata, d;
    logic [3:0]  muxChannel;
    logic [9:0]  convResult;
    logic [15:0] pinsGroupA;
    int          n_mismatch, n_tests, i;
    adcs_sequencer #(.CAL_CYCLES(CAL_CYC)) i_adcs_sequencer (
        .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
        .sampleEn(sampleEn), .convStart(convStart), .calRun(calRun),
        .muxGroup(muxGroup), .muxChannel(muxChannel),
        .convValid(convValid), .convResult(convResult), .calDone(calDone),
        .pinsGroupA(pinsGroupA), .pinsGroupB(pinsGroupB));
    adcs_core_model i_adcs_core_model (
        .clk(clk), .rst(rst), .calRun(calRun), .calHold(calHold),
        .convStart(convStart), .muxGroup(muxGroup),
        .muxChannel(muxChannel), .convValid(convValid),
        .convResult(convResult), .calDone(calDone));
    always #25 clk = ~clk;
    ////////////////////////////////////////////////////////////////////
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task timeout;
        n_mismatch++;
        $display("Error at %0t: wait timed out", $time);
        final_report;
    endtask
    task doReset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
    endtask
    task waitIrq;
        for (i = 0; i < 200 && irq !== 1'b1; i++)
            @(posedge clk);
        if (irq !== 1'b1)
            timeout;
    endtask
    task expRes(input logic g, input logic [3:0] ch);
        rd(`ADCS_PRIM_OFS);
        chk(d[9:0], {g, ch, 5'h0D});
        chk(d[15:12], ch);
    endtask
    task setup;
        wr(`ADCS_TIME_OFS, 32'h0000_0604);
        wr(`ADCS_IRQMSK_OFS, 32'h0000_0007);
        wr(`ADCS_SCANMSK_OFS, 32'h0000_0092);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 0; rst = 1; regWr = 0; regRd = 0; regAddr = 0; regWdata = 0;
        calHold = 1; pinsGroupA = 16'hA5C3; pinsGroupB = 8'h3C;
        n_mismatch = 0; n_tests = 0;
        doReset;
        repeat (4) @(posedge clk);
        rd(`ADCS_STAT_OFS);
        chk(d[0], 1'b1);
        wr(`ADCS_CTRL_OFS, 32'h0000_0045);
        repeat (CAL_CYC) @(posedge clk);
        rd(`ADCS_STAT_OFS);
        chk(d[1:0], 2'h0);
        $display("test calibration done");
        rd(`ADCS_TIME_OFS);
        chk(d[15:0], `ADCS_TIME_RST);
        rd(8'h40);
        chk(d, 32'h0000_0000);
        wr(8'h40, 32'h0000_FFFF);
        setup;
        wr(`ADCS_IRQMSK_OFS, 32'h0000_0000);
        rd(`ADCS_TIME_OFS);
        chk(d[15:0], 16'h0604);
        rd(`ADCS_PORT_OFS);
        chk(d[23:0], 24'h3C_A5C3);
        $display("test registers done");
        wr(`ADCS_CTRL_OFS, 32'h0000_0045);
        repeat (40) @(posedge clk);
        chk(irq, 1'b0);
        rd(`ADCS_STAT_OFS);
        chk(d[2:1], 2'h2);
        wr(`ADCS_IRQMSK_OFS, 32'h0000_0007);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        rd(`ADCS_IRQST_OFS);
        chk(d[1:0], 2'h1);
        @(posedge clk);
        chk(irq, 1'b0);
        expRes(1'b0, 4'h5);
        rd(`ADCS_STAT_OFS);
        chk(d[2:1], 2'h0);
        $display("test single done");
        for (int k = 0; k < 2; k++) begin
            wr(`ADCS_CTRL_OFS, 32'h0000_0143);
            repeat (40) @(posedge clk);
        end
        rd(`ADCS_IRQST_OFS);
        chk(d[1:0], 2'h3);
        expRes(1'b1, 4'h3);
        rd(`ADCS_STAT_OFS);
        chk(d[2], 1'b0);
        $display("test overrun done");
        wr(`ADCS_CTRL_OFS, 32'h0000_0061);
        for (int k = 1; k < 8; k += 3) begin
            waitIrq;
            rd(`ADCS_IRQST_OFS);
            expRes(1'b0, k[3:0]);
        end
        repeat (60) @(posedge clk);
        rd(`ADCS_STAT_OFS);
        chk(d[1], 1'b0);
        $display("test scan done");
        wr(`ADCS_CTRL_OFS, 32'h0000_00D2);
        repeat (80) @(posedge clk);
        rd(`ADCS_STAT_OFS);
        chk(d[3], 1'b1);
        rd(`ADCS_IRQST_OFS);
        chk(d[1], 1'b0);
        expRes(1'b0, 4'h2);
        repeat (40) @(posedge clk);
        rd(`ADCS_STAT_OFS);
        chk(d[3:1], 3'h7);
        $display("test wait for read done");
        calHold <= 1'b0;
        doReset;
        rd(`ADCS_STAT_OFS);
        chk(d[1:0], 2'h1);
        for (i = 0; i < CAL_CYC && d[0] !== 1'b0; i++)
            rd(`ADCS_STAT_OFS);
        if (d[0] !== 1'b0)
            timeout;
        setup;
        wr(`ADCS_CTRL_OFS, 32'h0000_0071);
        repeat (50) @(posedge clk);
        wr(`ADCS_CTRL_OFS, 32'h0000_2631);
        d = 0;
        for (i = 0; i < 100 && d[2] !== 1'b1; i++)
            rd(`ADCS_IRQST_OFS);
        if (d[2] !== 1'b1)
            timeout;
        rd(`ADCS_INJ_OFS);
        chk(d[9:0], 10'h12D);
        rd(`ADCS_STAT_OFS);
        chk(d[1], 1'b1);
        repeat (30) @(posedge clk);
        rd(`ADCS_PRIM_OFS);
        chk(d[15:12] inside {4'h1, 4'h4, 4'h7}, 1'b1);
        $display("test injection done");
        final_report;
    end
endmodule
